//--- hdl/ccrs_pkg.sv
// Package for the processor control register set: register map, fields, reset values.
// Assumes a 32-bit APB with word-aligned registers.
package ccrs_pkg;
    localparam logic [7:0] OFF_ISTACK   = 8'h00;
    localparam logic [7:0] OFF_USTACK   = 8'h04;
    localparam logic [7:0] OFF_VBASE    = 8'h08;
    localparam logic [7:0] OFF_PC       = 8'h0c;
    localparam logic [7:0] OFF_PSW      = 8'h10;
    localparam logic [7:0] OFF_BK_PC    = 8'h14;
    localparam logic [7:0] OFF_BK_PSW   = 8'h18;
    localparam logic [7:0] OFF_FAST_TGT = 8'h1c;
    localparam logic [7:0] OFF_FSTAT    = 8'h20;
    localparam logic [7:0] OFF_IRQ_ST   = 8'h24;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h28;
    localparam logic [7:0] OFF_IRQ_CL   = 8'h2c;
    // Stack select bit in status word
    localparam int PSW_U_BIT = 17;
    // Float status word fields: cause [6:2], enable [14:10], accumulated [30:26]
    localparam int FP_CAUSE_LSB = 2;
    localparam int FP_EN_LSB    = 10;
    localparam int FP_ACC_LSB   = 26;
    localparam int FP_KINDS     = 5;
    // Interrupt status bits
    localparam int IRQ_FAST_TAKEN = 0;
    localparam int IRQ_FAST_RET   = 1;
    localparam int IRQ_FP_EXC     = 2;
    localparam int IRQ_BITS       = 3;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_PC   = 32'h0000_0000;
endpackage

//--- hdl/ccrs_fp_flags.sv
// Floating-point exception flags: cause, accumulated and trap request.
// Assumes one exception report pulse per operation from the pipeline.
`timescale 1ns/1ps
`default_nettype none
module ccrs_fp_flags #(
    parameter int KINDS = ccrs_pkg::FP_KINDS
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Operation result
    input  wire logic             op_done,
    input  wire logic [KINDS-1:0] op_exc,
    input  wire logic [KINDS-1:0] enable,
    // Software write of flags
    input  wire logic             sw_wr,
    input  wire logic [KINDS-1:0] sw_cause,
    input  wire logic [KINDS-1:0] sw_acc,
    // State
    output logic      [KINDS-1:0] cause_ff,
    output logic      [KINDS-1:0] acc_ff,
    output logic                  trap
);
    logic [KINDS-1:0] nxt_cause;
    logic [KINDS-1:0] nxt_acc;
    wire  [KINDS-1:0] hit_en  = op_exc & enable;
    wire  [KINDS-1:0] hit_off = op_exc & ~enable;

    assign trap = op_done & (|hit_en);

    genvar j;
    generate
        for (j = 0; j < KINDS; j++) begin : g_kind
            // New cause on each op; a new event beats a software write
            assign nxt_cause[j] = op_done ? hit_en[j] : (sw_wr ? sw_cause[j] : cause_ff[j]);
            assign nxt_acc[j] = (op_done & hit_off[j]) | (sw_wr ? sw_acc[j] : acc_ff[j]);
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cause_ff <= '0;
            acc_ff   <= '0;
        end else begin
            cause_ff <= nxt_cause;
            acc_ff   <= nxt_acc;
        end
    end
endmodule
`default_nettype wire

//--- hdl/ccrs_irq.sv
// Sticky event status, enable mask and level interrupt output.
// Assumes events are one-cycle pulses from the register set.
`timescale 1ns/1ps
`default_nettype none
module ccrs_irq #(
    parameter int N = ccrs_pkg::IRQ_BITS
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Events and software control
    input  wire logic [N-1:0] event_in,
    input  wire logic         en_wr,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] wdata,
    // State
    output logic      [N-1:0] status_ff,
    output logic      [N-1:0] enable_ff,
    output logic              irq
);
    wire [N-1:0] nxt_status = event_in | (status_ff & ~(clr_wr ? wdata : '0));
    wire [N-1:0] nxt_enable = en_wr ? wdata : enable_ff;

    assign irq = |(status_ff & enable_ff);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_ff <= '0;
            enable_ff <= '0;
        end else begin
            status_ff <= nxt_status;
            enable_ff <= nxt_enable;
        end
    end
endmodule
`default_nettype wire

//--- hdl/ccrs_top.sv
// Processor control register set: stack pointers, vector base, program
// counter, fast interrupt backup and branch, float status word.
// Assumes pipeline strobes are one-cycle pulses synchronous to sys_clk.
//
// Behaviour
// - Stack pointer access goes to interrupt or user pointer per status bit.
// - General register zero is the active stack pointer.
// - Vector table base register locates interrupt vectors.
// - Program counter holds address of instruction being executed.
// - Fast interrupt copies program counter into backup program counter.
// - Fast interrupt copies status word into backup status word.
// - Backup status word keeps the status word bit layout.
// - Fast interrupt branches to fast interrupt target register.
// - Enabled float exception raises trap and sets cause flag.
// - Masked float exception sets accumulated flag without trap.
// - Accumulated flags hold one until software writes zero.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ccrs_top #(
    parameter int AW = 32
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Pipeline: program counter
    input  wire logic          pc_load,
    input  wire logic [AW-1:0] pc_next,
    // Pipeline: general register zero access
    input  wire logic [3:0]    gpr_sel,
    input  wire logic          gpr_wr,
    input  wire logic [AW-1:0] gpr_wdata,
    output logic      [AW-1:0] sp_rdata,
    output logic               sp_hit,
    // Pipeline: status word update
    input  wire logic          psw_wr,
    input  wire logic [31:0]   psw_wdata,
    // Interrupt controller
    input  wire logic          fast_irq_take,
    input  wire logic          fast_irq_return,
    input  wire logic [7:0]    vec_num,
    output logic      [AW-1:0] vec_addr,
    // Float unit
    input  wire logic          fp_op_done,
    input  wire logic [4:0]    fp_op_exc,
    output logic               fp_trap,
    // Control outputs
    output logic      [AW-1:0] program_counter,
    output logic      [31:0]   processor_status_word,
    output logic      [AW-1:0] active_stack_pointer,
    output logic               irq
);
    localparam int K = ccrs_pkg::FP_KINDS;
    localparam int NI = ccrs_pkg::IRQ_BITS;

    logic [AW-1:0] istack_ff, ustack_ff, vbase_ff, pc_ff, bk_pc_ff, fast_tgt_ff;
    logic [31:0]   psw_ff, bk_psw_ff;
    logic [1:0]    fstat_misc_ff;
    logic [K-1:0]  fp_en_ff, fp_cause, fp_acc;
    logic [NI-1:0] irq_status, irq_enable;

    // APB decode: zero-wait access, write on access phase
    wire apb_acc  = psel & penable;
    wire apb_wr   = apb_acc & pwrite;
    wire wr_istack   = apb_wr & (paddr == ccrs_pkg::OFF_ISTACK);
    wire wr_ustack   = apb_wr & (paddr == ccrs_pkg::OFF_USTACK);
    wire wr_vbase    = apb_wr & (paddr == ccrs_pkg::OFF_VBASE);
    wire wr_pc       = apb_wr & (paddr == ccrs_pkg::OFF_PC);
    wire wr_psw      = apb_wr & (paddr == ccrs_pkg::OFF_PSW);
    wire wr_bk_pc    = apb_wr & (paddr == ccrs_pkg::OFF_BK_PC);
    wire wr_bk_psw   = apb_wr & (paddr == ccrs_pkg::OFF_BK_PSW);
    wire wr_fast_tgt = apb_wr & (paddr == ccrs_pkg::OFF_FAST_TGT);
    wire wr_fstat    = apb_wr & (paddr == ccrs_pkg::OFF_FSTAT);
    wire wr_ien   = apb_wr & (paddr == ccrs_pkg::OFF_IRQ_EN);
    wire wr_iclr  = apb_wr & (paddr == ccrs_pkg::OFF_IRQ_CL);
    wire mapped   = (paddr <= ccrs_pkg::OFF_IRQ_CL) && (paddr[1:0] == 2'b00);

    // Stack select and register-zero routing
    wire use_user  = psw_ff[ccrs_pkg::PSW_U_BIT];
    wire zero_sel  = (gpr_sel == 4'h0);
    wire gpr_sp_wr = gpr_wr & zero_sel;
    assign active_stack_pointer = use_user ? ustack_ff : istack_ff;
    assign sp_rdata = active_stack_pointer;
    assign sp_hit   = zero_sel;

    // Vector lookup: base plus four bytes per vector
    assign vec_addr = vbase_ff + AW'({vec_num, 2'b00});

    // Next values; fast interrupt events beat software and pipeline writes
    wire [AW-1:0] nxt_istack = (gpr_sp_wr & ~use_user) ? gpr_wdata :
                               (wr_istack ? pwdata[AW-1:0] : istack_ff);
    wire [AW-1:0] nxt_ustack = (gpr_sp_wr & use_user) ? gpr_wdata :
                               (wr_ustack ? pwdata[AW-1:0] : ustack_ff);
    wire [AW-1:0] nxt_vbase = wr_vbase ? pwdata[AW-1:0] : vbase_ff;
    wire [AW-1:0] nxt_fast_tgt = wr_fast_tgt ? pwdata[AW-1:0] : fast_tgt_ff;
    wire [AW-1:0] nxt_pc = fast_irq_take   ? fast_tgt_ff :
                           fast_irq_return ? bk_pc_ff :
                           pc_load         ? pc_next :
                           wr_pc           ? pwdata[AW-1:0] : pc_ff;
    wire [31:0] nxt_psw = fast_irq_return ? bk_psw_ff :
                          psw_wr          ? psw_wdata :
                          wr_psw          ? pwdata : psw_ff;
    wire [AW-1:0] nxt_bk_pc = fast_irq_take ? pc_ff :
                              (wr_bk_pc ? pwdata[AW-1:0] : bk_pc_ff);
    // Whole-word copy keeps each bit in place
    wire [31:0] nxt_bk_psw = fast_irq_take ? psw_ff :
                             (wr_bk_psw ? pwdata : bk_psw_ff);
    wire [K-1:0] nxt_fp_en = wr_fstat ? pwdata[ccrs_pkg::FP_EN_LSB +: K] : fp_en_ff;
    wire [1:0] nxt_fstat_misc = wr_fstat ? pwdata[1:0] : fstat_misc_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            istack_ff     <= '0;
            ustack_ff     <= '0;
            vbase_ff      <= '0;
            fast_tgt_ff   <= '0;
            pc_ff         <= ccrs_pkg::RST_PC[AW-1:0];
            psw_ff        <= ccrs_pkg::RST_WORD;
            bk_pc_ff      <= '0;
            bk_psw_ff     <= ccrs_pkg::RST_WORD;
            fp_en_ff      <= '0;
            fstat_misc_ff <= 2'h0;
        end else begin
            istack_ff     <= nxt_istack;
            ustack_ff     <= nxt_ustack;
            vbase_ff      <= nxt_vbase;
            fast_tgt_ff   <= nxt_fast_tgt;
            pc_ff         <= nxt_pc;
            psw_ff        <= nxt_psw;
            bk_pc_ff      <= nxt_bk_pc;
            bk_psw_ff     <= nxt_bk_psw;
            fp_en_ff      <= nxt_fp_en;
            fstat_misc_ff <= nxt_fstat_misc;
        end
    end

    assign program_counter       = pc_ff;
    assign processor_status_word = psw_ff;

    // Float flags
    ccrs_fp_flags #(.KINDS(K)) u_fp (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .op_done  (fp_op_done),
        .op_exc   (fp_op_exc),
        .enable   (fp_en_ff),
        .sw_wr    (wr_fstat),
        .sw_cause (pwdata[ccrs_pkg::FP_CAUSE_LSB +: K]),
        .sw_acc   (pwdata[ccrs_pkg::FP_ACC_LSB +: K]),
        .cause_ff (fp_cause),
        .acc_ff   (fp_acc),
        .trap     (fp_trap)
    );

    wire [31:0] fstat_word = {1'b0, fp_acc, 11'h000, fp_en_ff, 3'h0,
                              fp_cause, fstat_misc_ff};

    // Event interrupts
    wire [NI-1:0] irq_events = {fp_trap, fast_irq_return, fast_irq_take};
    ccrs_irq #(.N(NI)) u_irq (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .event_in  (irq_events),
        .en_wr     (wr_ien),
        .clr_wr    (wr_iclr),
        .wdata     (pwdata[NI-1:0]),
        .status_ff (irq_status),
        .enable_ff (irq_enable),
        .irq       (irq)
    );

    // Read mux
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            ccrs_pkg::OFF_ISTACK:   rd_word = 32'(istack_ff);
            ccrs_pkg::OFF_USTACK:   rd_word = 32'(ustack_ff);
            ccrs_pkg::OFF_VBASE:    rd_word = 32'(vbase_ff);
            ccrs_pkg::OFF_PC:       rd_word = 32'(pc_ff);
            ccrs_pkg::OFF_PSW:      rd_word = psw_ff;
            ccrs_pkg::OFF_BK_PC:    rd_word = 32'(bk_pc_ff);
            ccrs_pkg::OFF_BK_PSW:   rd_word = bk_psw_ff;
            ccrs_pkg::OFF_FAST_TGT: rd_word = 32'(fast_tgt_ff);
            ccrs_pkg::OFF_FSTAT:    rd_word = fstat_word;
            ccrs_pkg::OFF_IRQ_ST:   rd_word = 32'(irq_status);
            ccrs_pkg::OFF_IRQ_EN:   rd_word = 32'(irq_enable);
            default:                rd_word = 32'h0000_0000;
        endcase
    end

    assign prdata  = rd_word;
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~mapped;
endmodule
`default_nettype wire

//--- verification/ccrs_top_assertions.sv
// Checker for the control register set, watching top-level ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ccrs_top_assertions #(
    parameter int AW = 32
) (
    // Clock and reset
    input wire logic          sys_clk,
    input wire logic          rst_n,
    // Register bus
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [7:0]    paddr,
    input wire logic          pready,
    input wire logic          pslverr,
    // Pipeline
    input wire logic          pc_load,
    input wire logic [AW-1:0] pc_next,
    input wire logic [3:0]    gpr_sel,
    input wire logic          gpr_wr,
    input wire logic [AW-1:0] gpr_wdata,
    input wire logic          psw_wr,
    input wire logic [AW-1:0] sp_rdata,
    input wire logic          sp_hit,
    // Interrupt and float
    input wire logic          fast_irq_take,
    input wire logic          fast_irq_return,
    input wire logic [7:0]    vec_num,
    input wire logic [AW-1:0] vec_addr,
    input wire logic          fp_op_done,
    input wire logic [4:0]    fp_op_exc,
    input wire logic          fp_trap,
    // State outputs
    input wire logic [AW-1:0] program_counter,
    input wire logic [31:0]   processor_status_word,
    input wire logic [AW-1:0] active_stack_pointer
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_sp_hit_decode: assert property (sp_hit == (gpr_sel == 4'h0))
        else $error("sp_hit does not follow register select");
    a_sp_read_mirror: assert property (sp_rdata == active_stack_pointer)
        else $error("register zero read differs from stack pointer");
    a_sp_gpr_write: assert property (gpr_wr && gpr_sel == 4'h0 && !psw_wr
        && !fast_irq_return && !(psel && penable)
        |=> active_stack_pointer == $past(gpr_wdata))
        else $error("register zero write missed stack pointer");
    a_pc_load_next: assert property (pc_load && !fast_irq_take && !fast_irq_return
        |=> program_counter == $past(pc_next))
        else $error("program counter missed load");
    a_fast_round_trip: assert property ((fast_irq_take && !psel)
        ##1 (fast_irq_return && !psel)
        |=> program_counter == $past(program_counter, 2)
        && processor_status_word == $past(processor_status_word, 2))
        else $error("fast return did not restore state");
    a_trap_needs_op: assert property (fp_trap |-> fp_op_done && fp_op_exc != 5'h0)
        else $error("float trap without an exception");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase not answered");
    a_bad_addr_err: assert property (psel && penable && (paddr > 8'h2c || paddr[1:0] != 2'h0)
        |-> pslverr)
        else $error("unmapped access not flagged");
    a_vec_step: assert property (!$past(psel) && vec_num != 8'h0
        && vec_num == $past(vec_num) + 8'h1 |-> vec_addr == $past(vec_addr) + 4)
        else $error("vector entry spacing wrong");
endmodule
`default_nettype wire

//--- verification/ccrs_irq_model.sv
// Interrupt controller and float unit stand-in: one-cycle strobes on request.
// Assumes each request is held for one cycle by the bench.
`timescale 1ns/1ps
`default_nettype none
module ccrs_irq_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Requests from the bench
    input  wire logic       req_take,
    input  wire logic       req_ret,
    input  wire logic       req_fp,
    input  wire logic [4:0] req_exc,
    // Strobes to the register set
    output logic            fast_irq_take,
    output logic            fast_irq_return,
    output logic            fp_op_done,
    output logic      [4:0] fp_op_exc
);
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fast_irq_take <= 1'b0;
            fast_irq_return <= 1'b0;
            fp_op_done <= 1'b0;
            fp_op_exc <= 5'h0;
        end else begin
            fast_irq_take <= req_take;
            fast_irq_return <= req_ret;
            fp_op_done <= req_fp;
            // Report lines toggle while no result is offered
            fp_op_exc <= req_fp ? req_exc : ~fp_op_exc;
        end
    end
endmodule
`default_nettype wire

//--- verification/ccrs_top_tb.sv
// Self-checking bench for the control register set, APB master and pipeline driver.
// Assumes the register map and field layout of the design package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, s) begin n_compared++; if ((s) !== (x)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, x, s); end end
module ccrs_top_tb;
    logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0]  paddr = 0, vec_num = 0, v;
    logic [31:0] pwdata = 0, pc_next = 0, gpr_wdata = 0, psw_wdata = 0, q, a, b, c, d, x;
    logic [31:0] prdata, sp_rdata, vec_addr, program_counter, processor_status_word;
    logic [31:0] active_stack_pointer, seed = 32'h0001_7af5;
    logic        pc_load = 0, gpr_wr = 0, psw_wr = 0, pready, pslverr, sp_hit, fp_trap, irq;
    logic        t_take = 0, t_ret = 0, t_fp = 0, fast_irq_take, fast_irq_return, fp_op_done;
    logic [3:0]  gpr_sel = 4'h1;
    logic [4:0]  t_exc = 0, fp_op_exc, fen, acc;
    int          mismatches = 0, n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    ccrs_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pc_load(pc_load), .pc_next(pc_next), .gpr_sel(gpr_sel),
        .gpr_wr(gpr_wr), .gpr_wdata(gpr_wdata), .sp_rdata(sp_rdata), .sp_hit(sp_hit),
        .psw_wr(psw_wr), .psw_wdata(psw_wdata), .fast_irq_take(fast_irq_take),
        .fast_irq_return(fast_irq_return), .vec_num(vec_num), .vec_addr(vec_addr),
        .fp_op_done(fp_op_done), .fp_op_exc(fp_op_exc), .fp_trap(fp_trap),
        .program_counter(program_counter), .processor_status_word(processor_status_word),
        .active_stack_pointer(active_stack_pointer), .irq(irq));
    ccrs_irq_model u_far (.sys_clk(sys_clk), .rst_n(rst_n), .req_take(t_take),
        .req_ret(t_ret), .req_fp(t_fp), .req_exc(t_exc), .fast_irq_take(fast_irq_take),
        .fast_irq_return(fast_irq_return), .fp_op_done(fp_op_done), .fp_op_exc(fp_op_exc));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [31:0] fpw(input logic [4:0] en, cs, ac);
        return {1'b0, ac, 11'h0, en, 3'h0, cs, 2'h0};
    endfunction
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task strobe(input int k);
        @(posedge sys_clk);
        if (k == 0) t_take <= 1'b1; else t_ret <= 1'b1;
        @(posedge sys_clk);
        t_take <= 1'b0;
        t_ret <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #50000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h10, 32'h0);
        `CHK("psw reset", 32'h0, q)
        a = rnd() & 32'hffff_fffc;
        b = rnd() & 32'hffff_fffc;
        apb(1'b1, 8'h00, a);
        apb(1'b1, 8'h04, b);
        apb(1'b1, 8'h10, 32'h0);
        `CHK("sp int", a, active_stack_pointer)
        apb(1'b1, 8'h10, 32'h0002_0000);
        @(negedge sys_clk);
        `CHK("sp user", b, active_stack_pointer)
        c = rnd();
        @(posedge sys_clk);
        gpr_sel <= 4'h0;
        gpr_wr <= 1'b1;
        gpr_wdata <= c;
        @(posedge sys_clk);
        gpr_wr <= 1'b0;
        gpr_sel <= 4'h1;
        apb(1'b0, 8'h04, 32'h0);
        `CHK("user via r0", c, q)
        apb(1'b0, 8'h00, 32'h0);
        `CHK("int kept", a, q)
        apb(1'b1, 8'h08, a);
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            vec_num <= c[7:0] + 8'(i);
        end
        v = c[7:0] + 8'h2;
        @(negedge sys_clk);
        `CHK("vector", a + {22'h0, v, 2'h0}, vec_addr)
        @(posedge sys_clk);
        pc_load <= 1'b1;
        pc_next <= c;
        @(posedge sys_clk);
        pc_load <= 1'b0;
        @(negedge sys_clk);
        `CHK("pc load", c, program_counter)
        d = rnd();
        apb(1'b1, 8'h1c, b);
        @(posedge sys_clk);
        psw_wr <= 1'b1;
        psw_wdata <= d;
        @(posedge sys_clk);
        psw_wr <= 1'b0;
        strobe(0);
        `CHK("fast target", b, program_counter)
        apb(1'b0, 8'h14, 32'h0);
        `CHK("backup pc", c, q)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("backup psw", d, q)
        apb(1'b0, 8'h24, 32'h0);
        `CHK("irq masked", 2'b10, {q[0], irq})
        apb(1'b1, 8'h28, 32'h1);
        @(negedge sys_clk);
        `CHK("irq on", 1'b1, irq)
        apb(1'b1, 8'h2c, 32'h1);
        @(negedge sys_clk);
        `CHK("irq clear", 1'b0, irq)
        strobe(1);
        `CHK("ret pc", c, program_counter)
        `CHK("ret psw", d, processor_status_word)
        @(posedge sys_clk);
        t_take <= 1'b1;
        @(posedge sys_clk);
        t_take <= 1'b0;
        t_ret <= 1'b1;
        @(posedge sys_clk);
        t_ret <= 1'b0;
        @(negedge sys_clk);
        `CHK("trip target", b, program_counter)
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("round trip", c, program_counter)
        for (int j = 0; j < 3; j++) begin
            fen = (j == 0) ? 5'h00 : (j == 1) ? 5'h1f : 5'(rnd());
            acc = 5'h0;
            apb(1'b1, 8'h20, fpw(fen, 5'h0, 5'h0));
            repeat (3) begin
                x = rnd();
                @(posedge sys_clk);
                t_fp <= 1'b1;
                t_exc <= x[4:0];
                @(posedge sys_clk);
                t_fp <= 1'b0;
                @(negedge sys_clk);
                `CHK("trap", |(x[4:0] & fen), fp_trap)
                acc = acc | (x[4:0] & ~fen);
                apb(1'b0, 8'h20, 32'h0);
                `CHK("float status", fpw(fen, x[4:0] & fen, acc), q)
            end
            apb(1'b1, 8'h20, fpw(fen, 5'h0, 5'h0));
            apb(1'b0, 8'h20, 32'h0);
            `CHK("float status cleared", fpw(fen, 5'h0, 5'h0), q)
        end
        // Mid-run reset: backup and program counter return to zero
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h14, 32'h0);
        `CHK("backup pc reset", 32'h0, q)
        `CHK("pc reset", 32'h0, program_counter)
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {e, q})
        report_and_stop;
    end
endmodule
bind ccrs_top ccrs_top_assertions #(.AW(AW)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .pc_load(pc_load), .pc_next(pc_next), .gpr_sel(gpr_sel), .sp_rdata(sp_rdata),
    .gpr_wr(gpr_wr), .gpr_wdata(gpr_wdata), .psw_wr(psw_wr),
    .sp_hit(sp_hit), .fast_irq_take(fast_irq_take), .fast_irq_return(fast_irq_return),
    .vec_num(vec_num), .vec_addr(vec_addr), .fp_op_done(fp_op_done),
    .fp_op_exc(fp_op_exc), .fp_trap(fp_trap), .program_counter(program_counter),
    .processor_status_word(processor_status_word),
    .active_stack_pointer(active_stack_pointer));
`default_nettype wire
